// ==== design/brownout_limiter_rate_config.sv ====
`timescale 1ns/1ps
module brownout_limiter_rate_config
    import brownout_limiter_pkg::*;
#(
    parameter int RELEASE_TICK_CYCLES = RELEASE_UNIT_CYCLES
)
(
    input  wire logic                                  sys_clk,
    input  wire logic                                  reset,
    input  wire brownout_limiter_pkg::reg_req_type     reg_req,
    output brownout_limiter_pkg::reg_rsp_type          reg_rsp,
    input  wire logic [2:0]                            brownout_level,
    input  wire logic                                  infinite_hold_enabled,
    input  wire logic [7:0]                            limit_target,
    input  wire brownout_limiter_pkg::supply_samples_type supply_samples,
    input  wire logic [brownout_limiter_pkg::ADC_W-1:0] level_up_threshold,
    output logic [7:0]                                 limit_attenuation,
    output logic                                       level_up_allowed,
    output logic                                       hold_release_strobe,
    output logic                                       brownout_engine_enable,
    output logic                                       limiter_enable,
    output logic [1:0]                                 supply_source_select,
    output logic [7:0]                                 level_up_hysteresis,
    output brownout_limiter_pkg::level_rates_type      active_rates
);
    import brownout_limiter_pkg::*;

    level_rates_type      lvl3_rates_q;
    level_rates_type      lvl3_rates_d;
    level_rates_type      lvl2_rates_q;
    level_rates_type      lvl2_rates_d;
    level_rates_type      lvl1_rates_q;
    level_rates_type      lvl1_rates_d;
    level_rates_type      lvl0_rates_q;
    level_rates_type      lvl0_rates_d;
    logic [7:0]           hysteresis_q;
    logic [7:0]           hysteresis_d;
    logic [1:0]           source_q;
    logic [1:0]           source_d;
    logic                 engine_en_q;
    logic                 engine_en_d;
    logic                 limit_en_q;
    logic                 limit_en_d;
    logic                 hold_release_q;
    logic                 hold_release_d;
    reg_rsp_type          rsp_q;
    reg_rsp_type          rsp_d;

    level_rates_type      sel_rates;
    level_rates_type      active_rates_q;
    logic [7:0]           atten_q;
    logic [7:0]           atten_d;
    logic                 level_up_q;
    logic                 level_up_d;
    logic [ADC_W-1:0]     sample;
    logic [ADC_W:0]       up_limit;

    logic                 attack_run;
    logic                 release_run;
    logic                 attack_tick;
    logic                 release_tick;
    logic                 attack_step;
    logic                 release_step;

    // Register writes and read answers
    always_comb
    begin
        lvl3_rates_d   = lvl3_rates_q;
        lvl2_rates_d   = lvl2_rates_q;
        lvl1_rates_d   = lvl1_rates_q;
        lvl0_rates_d   = lvl0_rates_q;
        hysteresis_d   = hysteresis_q;
        source_d       = source_q;
        engine_en_d    = engine_en_q;
        limit_en_d     = limit_en_q;
        hold_release_d = 1'b0;
        if (reg_req.wr)
        begin
            if (reg_req.addr == LVL3_RATES_ADDR)
            begin
                lvl3_rates_d = reg_req.wdata[RELEASE_MSB:ATTACK_LSB];
            end
            else if (reg_req.addr == LVL2_RATES_ADDR)
            begin
                lvl2_rates_d = reg_req.wdata[RELEASE_MSB:ATTACK_LSB];
            end
            else if (reg_req.addr == LVL1_RATES_ADDR)
            begin
                lvl1_rates_d = reg_req.wdata[RELEASE_MSB:ATTACK_LSB];
            end
            else if (reg_req.addr == LVL0_RATES_ADDR)
            begin
                lvl0_rates_d = reg_req.wdata[RELEASE_MSB:ATTACK_LSB];
            end
            else if (reg_req.addr == HYSTERESIS_ADDR)
            begin
                hysteresis_d = reg_req.wdata;
            end
            else if (reg_req.addr == HOLD_CLEAR_ADDR)
            begin
                // Pulse only for a one while hold is in force
                hold_release_d = reg_req.wdata[HOLD_BIT]
                                 & infinite_hold_enabled;
            end
            else if (reg_req.addr == SUPPLY_SOURCE_ADDR)
            begin
                source_d = reg_req.wdata[SRC_MSB:SRC_LSB];
            end
            else if (reg_req.addr == ENGINE_ENABLE_ADDR)
            begin
                engine_en_d = reg_req.wdata[ENGINE_EN_BIT];
                limit_en_d  = reg_req.wdata[LIMIT_EN_BIT];
            end
        end

        rsp_d.valid = reg_req.rd;
        rsp_d.rdata = 8'h00;
        if (reg_req.rd)
        begin
            if (reg_req.addr == LVL3_RATES_ADDR)
            begin
                rsp_d.rdata = {2'b00, lvl3_rates_q};
            end
            else if (reg_req.addr == LVL2_RATES_ADDR)
            begin
                rsp_d.rdata = {2'b00, lvl2_rates_q};
            end
            else if (reg_req.addr == LVL1_RATES_ADDR)
            begin
                rsp_d.rdata = {2'b00, lvl1_rates_q};
            end
            else if (reg_req.addr == LVL0_RATES_ADDR)
            begin
                rsp_d.rdata = {2'b00, lvl0_rates_q};
            end
            else if (reg_req.addr == HYSTERESIS_ADDR)
            begin
                rsp_d.rdata = hysteresis_q;
            end
            else if (reg_req.addr == SUPPLY_SOURCE_ADDR)
            begin
                rsp_d.rdata = {6'h00, source_q};
            end
            else if (reg_req.addr == ENGINE_ENABLE_ADDR)
            begin
                rsp_d.rdata = {6'h00, limit_en_q, engine_en_q};
            end
            else
            begin
                // Hold-clear and unmapped addresses read zero
                rsp_d.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            lvl3_rates_q   <= {RATE_CODE_RESET, RATE_CODE_RESET};
            lvl2_rates_q   <= {RATE_CODE_RESET, RATE_CODE_RESET};
            lvl1_rates_q   <= {RATE_CODE_RESET, RATE_CODE_RESET};
            lvl0_rates_q   <= {RATE_CODE_RESET, RATE_CODE_RESET};
            hysteresis_q   <= HYSTERESIS_RESET;
            source_q       <= SOURCE_RESET;
            engine_en_q    <= ENABLE_RESET;
            limit_en_q     <= ENABLE_RESET;
            hold_release_q <= 1'b0;
            rsp_q          <= '0;
        end
        else
        begin
            lvl3_rates_q   <= lvl3_rates_d;
            lvl2_rates_q   <= lvl2_rates_d;
            lvl1_rates_q   <= lvl1_rates_d;
            lvl0_rates_q   <= lvl0_rates_d;
            hysteresis_q   <= hysteresis_d;
            source_q       <= source_d;
            engine_en_q    <= engine_en_d;
            limit_en_q     <= limit_en_d;
            hold_release_q <= hold_release_d;
            rsp_q          <= rsp_d;
        end
    end

    // Rates of the current level; normal operation keeps level 3 rates
    always_comb
    begin
        case (brownout_level)
            LEVEL_2: sel_rates = lvl2_rates_q;
            LEVEL_1: sel_rates = lvl1_rates_q;
            LEVEL_0: sel_rates = lvl0_rates_q;
            default: sel_rates = lvl3_rates_q;
        endcase
    end

    // Supply sample in ADC LSBs, compared with threshold plus hysteresis
    always_comb
    begin
        case (source_q)
            SRC_BATTERY:       sample = supply_samples.battery;
            SRC_INTERNAL_RAIL: sample = supply_samples.internal_rail;
            default:           sample = supply_samples.high_rail;
        endcase
        up_limit   = {1'b0, level_up_threshold}
                     + {{(ADC_W + 1 - 8){1'b0}}, hysteresis_q};
        level_up_d = ({1'b0, sample} >= up_limit);
    end

    // Limiter runs only when enabled; attack tightens, release relaxes
    assign attack_run  = limit_en_q && (limit_target > atten_q);
    assign release_run = limit_en_q && (limit_target < atten_q);

    tick_divider #(
        .DIVIDE (ATTACK_UNIT_CYCLES)
    ) attack_div (
        .sys_clk (sys_clk),
        .reset   (reset),
        .run     (attack_run),
        .tick    (attack_tick)
    );

    tick_divider #(
        .DIVIDE (RELEASE_TICK_CYCLES)
    ) release_div (
        .sys_clk (sys_clk),
        .reset   (reset),
        .run     (release_run),
        .tick    (release_tick)
    );

    rate_step_timer attack_timer (
        .sys_clk (sys_clk),
        .reset   (reset),
        .run     (attack_run),
        .tick    (attack_tick),
        .units   (ATTACK_UNITS[sel_rates.attack_code]),
        .step    (attack_step)
    );

    rate_step_timer release_timer (
        .sys_clk (sys_clk),
        .reset   (reset),
        .run     (release_run),
        .tick    (release_tick),
        .units   (RELEASE_UNITS[sel_rates.release_code]),
        .step    (release_step)
    );

    // One attenuation LSB per elapsed interval
    always_comb
    begin
        atten_d = atten_q;
        if (!limit_en_q)
        begin
            atten_d = 8'h00;
        end
        else if (attack_step && attack_run)
        begin
            atten_d = atten_q + 8'h01;
        end
        else if (release_step && release_run)
        begin
            atten_d = atten_q - 8'h01;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            atten_q        <= 8'h00;
            level_up_q     <= 1'b0;
            active_rates_q <= '0;
        end
        else
        begin
            atten_q        <= atten_d;
            level_up_q     <= level_up_d;
            active_rates_q <= sel_rates;
        end
    end

    assign reg_rsp                = rsp_q;
    assign limit_attenuation      = atten_q;
    assign level_up_allowed       = level_up_q;
    assign hold_release_strobe    = hold_release_q;
    assign brownout_engine_enable = engine_en_q;
    assign limiter_enable         = limit_en_q;
    assign supply_source_select   = source_q;
    assign level_up_hysteresis    = hysteresis_q;
    assign active_rates           = active_rates_q;
endmodule

// ==== design/brownout_limiter_pkg.sv ====
package brownout_limiter_pkg;

    // Register port
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    localparam logic [15:0] LVL3_RATES_ADDR     = 16'h2102;
    localparam logic [15:0] LVL2_RATES_ADDR     = 16'h2103;
    localparam logic [15:0] LVL1_RATES_ADDR     = 16'h2104;
    localparam logic [15:0] LVL0_RATES_ADDR     = 16'h2105;
    localparam logic [15:0] HYSTERESIS_ADDR     = 16'h2106;
    localparam logic [15:0] HOLD_CLEAR_ADDR     = 16'h2107;
    localparam logic [15:0] SUPPLY_SOURCE_ADDR  = 16'h2108;
    localparam logic [15:0] ENGINE_ENABLE_ADDR  = 16'h210D;

    // Field positions
    localparam int RELEASE_MSB   = 5;
    localparam int RELEASE_LSB   = 3;
    localparam int ATTACK_MSB    = 2;
    localparam int ATTACK_LSB    = 0;
    localparam int HOLD_BIT      = 0;
    localparam int ENGINE_EN_BIT = 0;
    localparam int LIMIT_EN_BIT  = 1;
    localparam int SRC_MSB       = 1;
    localparam int SRC_LSB       = 0;

    // Reset values
    localparam logic [2:0] RATE_CODE_RESET  = 3'h0;
    localparam logic [7:0] HYSTERESIS_RESET = 8'h00;
    localparam logic [1:0] SOURCE_RESET     = 2'h0;
    localparam logic       ENABLE_RESET     = 1'b0;

    // Source select codes
    localparam logic [1:0] SRC_HIGH_RAIL     = 2'h0;
    localparam logic [1:0] SRC_BATTERY       = 2'h1;
    localparam logic [1:0] SRC_INTERNAL_RAIL = 2'h2;

    // Level encoding of the controller state
    localparam logic [2:0] LEVEL_NONE = 3'h0;
    localparam logic [2:0] LEVEL_3    = 3'h1;
    localparam logic [2:0] LEVEL_2    = 3'h2;
    localparam logic [2:0] LEVEL_1    = 3'h3;
    localparam logic [2:0] LEVEL_0    = 3'h4;

    localparam int ADC_W = 10;

    // Timing: unit intervals and derived cycle counts
    localparam int CLK_PERIOD_PS      = 25000;
    localparam int ATTACK_UNIT_PS     = 2500000;
    localparam int RELEASE_UNIT_MS    = 5;
    localparam int ATTACK_UNIT_CYCLES =
        (ATTACK_UNIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Cycles per millisecond first, so the product stays inside 32 bits
    localparam int RELEASE_UNIT_CYCLES =
        RELEASE_UNIT_MS * (1000000000 / CLK_PERIOD_PS);

    // Step interval in units: attack 2.5us units, release 5ms units
    localparam logic [7:0] ATTACK_UNITS [0:7] =
        '{8'h01, 8'h02, 8'h04, 8'h0A, 8'h14, 8'h28, 8'h64, 8'hC8};
    localparam logic [7:0] RELEASE_UNITS [0:7] =
        '{8'h01, 8'h02, 8'h05, 8'h0A, 8'h14, 8'h32, 8'h64, 8'hC8};

    typedef struct packed {
        logic                  wr;
        logic                  rd;
        logic [ADDR_W-1:0]     addr;
        logic [DATA_W-1:0]     wdata;
    } reg_req_type;

    typedef struct packed {
        logic                  valid;
        logic [DATA_W-1:0]     rdata;
    } reg_rsp_type;

    typedef struct packed {
        logic [2:0] release_code;
        logic [2:0] attack_code;
    } level_rates_type;

    typedef struct packed {
        logic [ADC_W-1:0] high_rail;
        logic [ADC_W-1:0] battery;
        logic [ADC_W-1:0] internal_rail;
    } supply_samples_type;

endpackage

// ==== design/tick_divider.sv ====
`timescale 1ns/1ps
module tick_divider
#(
    parameter int DIVIDE = 100
)
(
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic run,
    output logic      tick
);
    logic [31:0] count_q;
    logic [31:0] count_d;
    logic        tick_d;

    always_comb
    begin
        count_d = count_q;
        tick_d  = 1'b0;
        if (!run)
        begin
            count_d = 32'h0;
        end
        else if (count_q == 32'(DIVIDE - 1))
        begin
            count_d = 32'h0;
            tick_d  = 1'b1;
        end
        else
        begin
            count_d = count_q + 32'h1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            count_q <= 32'h0;
            tick    <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            tick    <= tick_d;
        end
    end
endmodule

// ==== design/rate_step_timer.sv ====
`timescale 1ns/1ps
module rate_step_timer
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       run,
    input  wire logic       tick,
    input  wire logic [7:0] units,
    output logic            step
);
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic       step_d;

    // Counts unit ticks; one step pulse per elapsed interval
    always_comb
    begin
        count_d = count_q;
        step_d  = 1'b0;
        if (!run)
        begin
            count_d = 8'h00;
        end
        else if (tick)
        begin
            if (count_q + 8'h01 >= units)
            begin
                count_d = 8'h00;
                step_d  = 1'b1;
            end
            else
            begin
                count_d = count_q + 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            count_q <= 8'h00;
            step    <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            step    <= step_d;
        end
    end
endmodule

// ==== bench/brownout_limiter_rate_config_sva.sv ====
`timescale 1ns/1ps
module brownout_limiter_rate_config_sva
    import brownout_limiter_pkg::*;
(
    input wire logic                                    sys_clk,
    input wire logic                                    reset,
    input wire brownout_limiter_pkg::reg_req_type       reg_req,
    input wire brownout_limiter_pkg::reg_rsp_type       reg_rsp,
    input wire logic                                    infinite_hold_enabled,
    input wire brownout_limiter_pkg::supply_samples_type supply_samples,
    input wire logic [brownout_limiter_pkg::ADC_W-1:0]  level_up_threshold,
    input wire logic [7:0]                              limit_attenuation,
    input wire logic                                    level_up_allowed,
    input wire logic                                    hold_release_strobe,
    input wire logic                                    limiter_enable,
    input wire logic [1:0]                              supply_source_select,
    input wire logic [7:0]                              level_up_hysteresis
);
    import brownout_limiter_pkg::*;
    localparam int MIN_ATTACK_GAP = 98;
    logic [ADC_W-1:0] pick;
    logic [ADC_W:0]   need;
    logic             up_ok;
    logic [7:0]       att_prev_q;
    logic [7:0]       gap_q;
    logic [7:0]       gap_d;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    always_comb
    begin
        case (supply_source_select)
            SRC_BATTERY:       pick = supply_samples.battery;
            SRC_INTERNAL_RAIL: pick = supply_samples.internal_rail;
            default:           pick = supply_samples.high_rail;
        endcase
        need  = {1'b0, level_up_threshold} + {3'h0, level_up_hysteresis};
        up_ok = {1'b0, pick} >= need;
        gap_d = (limit_attenuation != att_prev_q) ? 8'h00 :
                (gap_q == 8'hFF) ? gap_q : gap_q + 8'h01;
    end

    // Cycles since the attenuation last moved
    always_ff @(posedge sys_clk)
    begin
        att_prev_q <= reset ? 8'h00 : limit_attenuation;
        gap_q      <= reset ? 8'h00 : gap_d;
    end

    sequence s_hold_write;
        reg_req.wr && reg_req.addr == HOLD_CLEAR_ADDR &&
        reg_req.wdata[HOLD_BIT] && infinite_hold_enabled;
    endsequence
    sequence s_rate_read;
        reg_req.rd && reg_req.addr >= LVL3_RATES_ADDR &&
        reg_req.addr <= LVL0_RATES_ADDR;
    endsequence

    a_hold_pulse: assert property (s_hold_write |=> hold_release_strobe)
        else $error("hold release pulse missing");
    a_hold_cause: assert property (hold_release_strobe |->
        $past(reg_req.wr) && $past(reg_req.addr) == HOLD_CLEAR_ADDR &&
        $past(reg_req.wdata[HOLD_BIT]) && $past(infinite_hold_enabled))
        else $error("hold release pulse without cause");
    a_hold_read_zero: assert property (reg_req.rd &&
        reg_req.addr == HOLD_CLEAR_ADDR |=> reg_rsp.valid && reg_rsp.rdata == 0)
        else $error("hold clear register read not zero");
    a_rate_upper_zero: assert property (s_rate_read |=>
        reg_rsp.valid && reg_rsp.rdata[7:6] == 2'h0)
        else $error("rate register read wrong");
    a_hyst_write: assert property (reg_req.wr &&
        reg_req.addr == HYSTERESIS_ADDR |=>
        level_up_hysteresis == $past(reg_req.wdata))
        else $error("hysteresis not written");
    a_level_up_cmp: assert property (!$past(reset) |->
        level_up_allowed == $past(up_ok))
        else $error("level up decision wrong");
    a_src_write: assert property (reg_req.wr &&
        reg_req.addr == SUPPLY_SOURCE_ADDR |=>
        supply_source_select == $past(reg_req.wdata[1:0]))
        else $error("source select not written");
    a_limit_off: assert property (!limiter_enable |=>
        limit_attenuation == 8'h00)
        else $error("attenuation while limiter off");
    a_step_size: assert property (limiter_enable && $past(limiter_enable) |->
        limit_attenuation - $past(limit_attenuation) inside {8'h00, 8'h01, 8'hFF})
        else $error("attenuation moved more than one step");
    a_attack_gap: assert property (limiter_enable &&
        limit_attenuation == att_prev_q + 8'h01 |-> gap_q >= MIN_ATTACK_GAP)
        else $error("attack steps too close");
endmodule

bind brownout_limiter_rate_config brownout_limiter_rate_config_sva i_sva (
    .sys_clk(sys_clk), .reset(reset), .reg_req(reg_req), .reg_rsp(reg_rsp),
    .infinite_hold_enabled(infinite_hold_enabled),
    .supply_samples(supply_samples), .level_up_threshold(level_up_threshold),
    .limit_attenuation(limit_attenuation),
    .level_up_allowed(level_up_allowed),
    .hold_release_strobe(hold_release_strobe),
    .limiter_enable(limiter_enable),
    .supply_source_select(supply_source_select),
    .level_up_hysteresis(level_up_hysteresis));

// ==== bench/tb_brownout_limiter_rate_config.sv ====
`timescale 1ns/1ps
module tb_brownout_limiter_rate_config;
    import brownout_limiter_pkg::*;
    localparam int REL_TICKS = 20;
    logic               sys_clk;
    logic               reset;
    reg_req_type        reg_req;
    reg_rsp_type        reg_rsp;
    logic [2:0]         brownout_level;
    logic               infinite_hold_enabled;
    logic [7:0]         limit_target;
    supply_samples_type supply_samples;
    logic [ADC_W-1:0]   level_up_threshold;
    logic [7:0]         limit_attenuation;
    logic               level_up_allowed;
    logic               hold_release_strobe;
    logic               engine_en;
    logic               limiter_enable;
    logic [1:0]         supply_source_select;
    logic [7:0]         level_up_hysteresis;
    level_rates_type    active_rates;
    int                 error_cnt;
    int                 total_checks;
    logic               strobe_seen;
    logic [7:0]         rd_val;

    brownout_limiter_rate_config #(.RELEASE_TICK_CYCLES(REL_TICKS))
    i_brownout_limiter_rate_config (
        .sys_clk(sys_clk), .reset(reset), .reg_req(reg_req),
        .reg_rsp(reg_rsp), .brownout_level(brownout_level),
        .infinite_hold_enabled(infinite_hold_enabled),
        .limit_target(limit_target), .supply_samples(supply_samples),
        .level_up_threshold(level_up_threshold),
        .limit_attenuation(limit_attenuation),
        .level_up_allowed(level_up_allowed),
        .hold_release_strobe(hold_release_strobe),
        .brownout_engine_enable(engine_en),
        .limiter_enable(limiter_enable),
        .supply_source_select(supply_source_select),
        .level_up_hysteresis(level_up_hysteresis),
        .active_rates(active_rates));

    always #12.5 sys_clk = ~sys_clk;

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        reg_req.wr = 1'b1;
        reg_req.addr = a;
        reg_req.wdata = d;
        step(1);
        reg_req.wr = 1'b0;
        strobe_seen = hold_release_strobe;
        step(1);
    endtask

    task automatic reg_rd(input logic [15:0] a, input logic [7:0] exp);
        reg_req.rd = 1'b1;
        reg_req.addr = a;
        step(1);
        reg_req.rd = 1'b0;
        chk("read valid", 8'h01, {7'h00, reg_rsp.valid});
        chk("read data", exp, reg_rsp.rdata);
        step(1);
    endtask

    task automatic wait_att(input logic [7:0] v, input int lo, input int hi);
        int n;
        n = 0;
        while (limit_attenuation !== v && n <= hi)
        begin
            step(1);
            n++;
        end
        chk("step cycles in range", 8'h01, {7'h00, n >= lo && n <= hi});
        if (n > hi)
            tally_and_finish();
    endtask

    task automatic check_reset_values();
        logic [15:0] regs [8];
        regs = '{16'h2102, 16'h2103, 16'h2104, 16'h2105, 16'h2106,
                 16'h2107, 16'h2108, 16'h210D};
        foreach (regs[i])
            reg_rd(regs[i], 8'h00);
        chk("attenuation at reset", 8'h00, limit_attenuation);
    endtask

    task automatic check_rate_regs();
        logic [7:0] vals [4];
        vals = '{8'hFF, 8'h2D, 8'h52, 8'hC7};
        for (int i = 0; i < 4; i++)
            reg_wr(LVL3_RATES_ADDR + 16'(i), vals[i]);
        for (int i = 0; i < 4; i++)
        begin
            reg_rd(LVL3_RATES_ADDR + 16'(i), vals[i] & 8'h3F);
            brownout_level = 3'(i + 1);
            step(3);
            chk("active rates", vals[i] & 8'h3F, {2'h0, active_rates});
        end
        reg_rd(16'h2110, 8'h00);
    endtask

    task automatic check_hysteresis();
        reg_wr(HYSTERESIS_ADDR, 8'hFF);
        reg_rd(HYSTERESIS_ADDR, 8'hFF);
        reg_wr(HYSTERESIS_ADDR, 8'h05);
        reg_wr(SUPPLY_SOURCE_ADDR, 8'h01);
        level_up_threshold = 10'h064;
        supply_samples.battery = 10'h068;
        step(3);
        chk("hysteresis out", 8'h05, level_up_hysteresis);
        chk("level up below", 8'h00, {7'h00, level_up_allowed});
        supply_samples.battery = 10'h069;
        step(3);
        chk("level up at edge", 8'h01, {7'h00, level_up_allowed});
        reg_wr(SUPPLY_SOURCE_ADDR, 8'h02);
        chk("source out", 8'h02, {6'h00, supply_source_select});
        reg_rd(SUPPLY_SOURCE_ADDR, 8'h02);
        chk("level up other rail", 8'h00, {7'h00, level_up_allowed});
    endtask

    task automatic check_hold_release();
        reg_wr(HOLD_CLEAR_ADDR, 8'h01);
        chk("strobe without hold", 8'h00, {7'h00, strobe_seen});
        infinite_hold_enabled = 1'b1;
        reg_wr(HOLD_CLEAR_ADDR, 8'h00);
        chk("strobe on zero", 8'h00, {7'h00, strobe_seen});
        reg_wr(HOLD_CLEAR_ADDR, 8'h01);
        chk("strobe on one", 8'h01, {7'h00, strobe_seen});
        reg_rd(HOLD_CLEAR_ADDR, 8'h00);
        infinite_hold_enabled = 1'b0;
    endtask

    task automatic check_limiter();
        reg_wr(LVL3_RATES_ADDR, 8'h03);
        brownout_level = 3'h1;
        limit_target = 8'h02;
        reg_wr(ENGINE_ENABLE_ADDR, 8'h03);
        wait_att(8'h01, 995, 1005);
        wait_att(8'h02, 995, 1005);
        limit_target = 8'h00;
        wait_att(8'h01, 15, 25);
        limit_target = 8'h04;
        reg_wr(ENGINE_ENABLE_ADDR, 8'h01);
        chk("attenuation when off", 8'h00, limit_attenuation);
        chk("engine enable out", 8'h01, {7'h00, engine_en});
        chk("limiter enable out", 8'h00, {7'h00, limiter_enable});
        reg_rd(ENGINE_ENABLE_ADDR, 8'h01);
        step(1100);
        chk("attenuation stays off", 8'h00, limit_attenuation);
    endtask

    initial
    begin
        sys_clk = 1'b0;
        reset = 1'b1;
        reg_req = '0;
        brownout_level = 3'h0;
        infinite_hold_enabled = 1'b0;
        limit_target = 8'h00;
        supply_samples = '0;
        level_up_threshold = '0;
        error_cnt = 0;
        total_checks = 0;
        strobe_seen = 1'b0;
        repeat (6) @(posedge sys_clk);
        #1;
        reset = 1'b0;
        check_reset_values();
        check_rate_regs();
        check_hysteresis();
        check_hold_release();
        check_limiter();
        tally_and_finish();
    end
endmodule
